// ### rtl/pci_config_header_fn1.sv
// Configuration header slice of the graphics function: command, class and latency registers.
`timescale 1ns/1ps
module pci_config_header_fn1
   import cfg_hdr_pkg::*;
#(
   parameter logic [7:0] SILICON_REVISION = 8'h5A // Arbitrary value.
)
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic reset_i,
   // Configuration access port.
   input wire logic cfg_sel_i,
   input wire logic cfg_write_i,
   input wire cfg_write_t cfg_req_i,
   output logic [31:0] cfg_rdata_o,
   // Memory target decode.
   input wire logic mem_hit_i,
   input wire logic rom_hit_i,
   input wire logic rom_decode_en_i,
   output logic mem_claim_o,
   // Bus master requests from the graphics engine.
   input wire master_ctl_t master_i,
   output logic master_req_o,
   output logic [3:0] master_write_cmd_o,
   output logic master_start_o,
   output logic master_stop_o,
   // System error pin.
   input wire logic serr_event_i,
   output logic serr_n_o,
   output logic serr_oe_o,
   // Command bits for other logic.
   output logic [15:0] command_o
);
   logic [15:0] command_control_field;
   logic [4:0] latency_field;
   logic [31:0] next_command_word;
   logic [31:0] next_latency_word;
   logic master_active;
   logic latency_expired;

   function automatic logic [31:0] class_word(input logic [7:0] rev);
      class_word = {CLASS_CODE, rev};
   endfunction : class_word

   // Registers are decoded by dword, so byte accesses inside a register still hit it.
   function automatic logic reg_hit(input logic [7:0] ofs, input logic [7:0] base);
      reg_hit = (ofs[7:2] == base[7:2]);
   endfunction : reg_hit

   cfg_byte_merge #(.WIDTH(32)) u_cmd_merge (
      .old_i({16'h0000, command_control_field}),
      .new_i(cfg_req_i.data),
      .byte_en_i(cfg_req_i.byte_en),
      .mask_i({16'h0000, CMD_WRITE_MASK}),
      .merged_o(next_command_word)
   );

   cfg_byte_merge #(.WIDTH(32)) u_lat_merge (
      .old_i({16'h0000, latency_field, 11'h000}),
      .new_i(cfg_req_i.data),
      .byte_en_i(cfg_req_i.byte_en),
      .mask_i(32'h0000F800),
      .merged_o(next_latency_word)
   );

   // Command register: reserved bits 7:5 store, bits 15:9 and 3 read zero.
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         command_control_field <= CMD_RESET;
      else if (cfg_sel_i && cfg_write_i && reg_hit(cfg_req_i.offset, OFS_COMMAND))
         command_control_field <= next_command_word[15:0];
   end

   // Latency timer field.
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         latency_field <= LAT_RESET;
      else if (cfg_sel_i && cfg_write_i && reg_hit(cfg_req_i.offset, OFS_HDR_LAT))
         latency_field <= next_latency_word[LAT_MSB:LAT_LSB];
   end

   // Read data; writes to offset 08h have no path and are dropped.
   // A byte read at 09h to 0Bh returns the whole word, so each class byte sits in its own lane.
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         cfg_rdata_o <= 32'h00000000;
      else if (cfg_sel_i && !cfg_write_i)
      begin
         unique case (cfg_req_i.offset[7:2])
            OFS_COMMAND[7:2]: cfg_rdata_o <= {16'h0000, command_control_field};
            OFS_CLASS_REV[7:2]: cfg_rdata_o <= class_word(SILICON_REVISION);
            OFS_HDR_LAT[7:2]: cfg_rdata_o <= {8'h00, HEADER_MULTI, latency_field, 11'h000};
            default: cfg_rdata_o <= 32'h00000000;
         endcase
      end
   end

   assign command_o = command_control_field;

   // Memory and ROM decode.
   always_comb
   begin
      mem_claim_o = command_control_field[BIT_MEM] &&
         (mem_hit_i || (rom_hit_i && rom_decode_en_i));
   end

   // Bus master gating and command choice.
   assign master_req_o = master_i.req && command_control_field[BIT_MASTER];
   assign master_start_o = master_req_o && master_i.gnt && !master_active;
   assign master_write_cmd_o = (master_i.want_mwi && command_control_field[BIT_MWI]) ?
      PCI_CMD_MWI : PCI_CMD_MEM_WRITE;

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         master_active <= 1'b0;
      else if (master_start_o)
         master_active <= 1'b1;
      else if (master_i.burst_done || master_stop_o || !command_control_field[BIT_MASTER])
         master_active <= 1'b0;
   end

   latency_limiter u_latency (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .lat_field_i(latency_field),
      .start_i(master_start_o),
      .active_i(master_active),
      .gnt_i(master_i.gnt),
      .expired_o(latency_expired),
      .stop_o(master_stop_o)
   );

   // System error driver, active low, enabled only by command bit 8.
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         serr_n_o <= 1'b1;
         serr_oe_o <= 1'b0;
      end
      else
      begin
         serr_n_o <= !(serr_event_i && command_control_field[BIT_SERR]);
         serr_oe_o <= serr_event_i && command_control_field[BIT_SERR];
      end
   end

   chk_serr_gated: assert property (@(posedge clk_i) disable iff (reset_i)
      serr_oe_o |-> $past(command_control_field[BIT_SERR]) && $past(serr_event_i))
      else $error("system error driven while disabled");
   chk_serr_enabled: assert property (@(posedge clk_i) disable iff (reset_i)
      (serr_event_i && command_control_field[BIT_SERR]) |=> serr_oe_o && !serr_n_o)
      else $error("system error not driven while enabled");
   chk_serr_quiet: assert property (@(posedge clk_i) disable iff (reset_i)
      !serr_oe_o |-> serr_n_o)
      else $error("system error pin low while not driven");
   chk_mwi_select: assert property (@(posedge clk_i) disable iff (reset_i)
      (master_write_cmd_o == PCI_CMD_MWI) |-> command_control_field[BIT_MWI])
      else $error("write-and-invalidate used while not permitted");
   chk_mwi_used: assert property (@(posedge clk_i) disable iff (reset_i)
      (master_i.want_mwi && command_control_field[BIT_MWI]) |->
      master_write_cmd_o == PCI_CMD_MWI)
      else $error("write-and-invalidate not used while permitted and wanted");
   chk_master_gate: assert property (@(posedge clk_i) disable iff (reset_i)
      !command_control_field[BIT_MASTER] |-> !master_req_o && !master_start_o)
      else $error("master request while mastering disabled");
   chk_active_drop: assert property (@(posedge clk_i) disable iff (reset_i)
      !command_control_field[BIT_MASTER] |=> !master_active)
      else $error("master tenure kept after mastering disabled");
   chk_mem_decode: assert property (@(posedge clk_i) disable iff (reset_i)
      mem_claim_o |-> command_control_field[BIT_MEM])
      else $error("memory claimed while decode disabled");
   chk_mem_claim_hit: assert property (@(posedge clk_i) disable iff (reset_i)
      (command_control_field[BIT_MEM] && mem_hit_i) |-> mem_claim_o)
      else $error("memory hit not claimed while decode enabled");
   chk_rom_claim: assert property (@(posedge clk_i) disable iff (reset_i)
      (rom_hit_i && !mem_hit_i && mem_claim_o) |-> rom_decode_en_i)
      else $error("rom claimed without rom enable");
   chk_rom_both: assert property (@(posedge clk_i) disable iff (reset_i)
      (command_control_field[BIT_MEM] && rom_hit_i && rom_decode_en_i) |-> mem_claim_o)
      else $error("rom hit not claimed with both enables set");
   chk_cmd_reset: assert property (@(posedge clk_i)
      reset_i |=> command_control_field == 16'h0000 && latency_field == 5'h00)
      else $error("control bits not cleared by reset");
   chk_cmd_write: assert property (@(posedge clk_i) disable iff (reset_i)
      (cfg_sel_i && cfg_write_i && reg_hit(cfg_req_i.offset, OFS_COMMAND) &&
      cfg_req_i.byte_en[0]) |=> command_control_field[BIT_IO] == $past(cfg_req_i.data[BIT_IO]))
      else $error("io bit not written");
   chk_io_no_effect: assert property (@(posedge clk_i) disable iff (reset_i)
      (command_control_field[BIT_IO] && !command_control_field[BIT_MEM]) |-> !mem_claim_o)
      else $error("io bit affected decoding");
   chk_class_read: assert property (@(posedge clk_i) disable iff (reset_i)
      (cfg_sel_i && !cfg_write_i && reg_hit(cfg_req_i.offset, OFS_CLASS_REV)) |=>
      cfg_rdata_o[31:8] == 24'h048000)
      else $error("class code read wrong");
   chk_class_no_write: assert property (@(posedge clk_i) disable iff (reset_i)
      (cfg_sel_i && cfg_write_i && reg_hit(cfg_req_i.offset, OFS_CLASS_REV)) |=>
      $stable(command_control_field) && $stable(latency_field))
      else $error("class register write changed state");
   chk_revision_read: assert property (@(posedge clk_i) disable iff (reset_i)
      (cfg_sel_i && !cfg_write_i && reg_hit(cfg_req_i.offset, OFS_CLASS_REV)) |=>
      cfg_rdata_o[7:0] == SILICON_REVISION)
      else $error("silicon revision read wrong");
   chk_header_read: assert property (@(posedge clk_i) disable iff (reset_i)
      (cfg_sel_i && !cfg_write_i && reg_hit(cfg_req_i.offset, OFS_HDR_LAT)) |=>
      cfg_rdata_o[23:16] == 8'h80 && cfg_rdata_o[15:11] == $past(latency_field))
      else $error("header type or latency read wrong");
   chk_lat_write: assert property (@(posedge clk_i) disable iff (reset_i)
      (cfg_sel_i && cfg_write_i && reg_hit(cfg_req_i.offset, OFS_HDR_LAT) &&
      cfg_req_i.byte_en[1]) |=> latency_field == $past(cfg_req_i.data[LAT_MSB:LAT_LSB]))
      else $error("latency timer not written");
   chk_stop_grant: assert property (@(posedge clk_i) disable iff (reset_i)
      (latency_expired && master_i.gnt) |-> !master_stop_o)
      else $error("burst stopped while grant still held");
   chk_stop_ends: assert property (@(posedge clk_i) disable iff (reset_i)
      master_stop_o |=> !master_active)
      else $error("tenure continued after forced stop");
endmodule : pci_config_header_fn1

// ### rtl/cfg_hdr_pkg.sv
// Package with offsets, field positions, reset values and types for the configuration header.
package cfg_hdr_pkg;
   localparam logic [7:0] OFS_COMMAND = 8'h04;
   localparam logic [7:0] OFS_CLASS_REV = 8'h08;
   localparam logic [7:0] OFS_HDR_LAT = 8'h0C;
   localparam int BIT_IO = 0;
   localparam int BIT_MEM = 1;
   localparam int BIT_MASTER = 2;
   localparam int BIT_MWI = 4;
   localparam int BIT_SERR = 8;
   localparam logic [15:0] CMD_WRITE_MASK = 16'h01F7;
   localparam logic [15:0] CMD_RESET = 16'h0000;
   localparam logic [23:0] CLASS_CODE = 24'h048000;
   localparam logic [7:0] HEADER_MULTI = 8'h80;
   localparam int LAT_LSB = 11;
   localparam int LAT_MSB = 15;
   localparam logic [4:0] LAT_RESET = 5'h00;
   localparam int LAT_UNIT_CLOCKS = 8;
   localparam logic [3:0] PCI_CMD_MEM_WRITE = 4'h7;
   localparam logic [3:0] PCI_CMD_MWI = 4'hF;

   typedef struct packed {
      logic [7:0] offset;
      logic [3:0] byte_en;
      logic [31:0] data;
   } cfg_write_t;

   typedef struct packed {
      logic req;
      logic want_mwi;
      logic gnt;
      logic burst_done;
   } master_ctl_t;
endpackage : cfg_hdr_pkg

// ### rtl/cfg_byte_merge.sv
// Byte-lane merge of a configuration write into a register word.
`timescale 1ns/1ps
module cfg_byte_merge
   import cfg_hdr_pkg::*;
#(
   parameter int WIDTH = 32
)
(
   // Old value, new data, enables and writable mask.
   input wire logic [WIDTH-1:0] old_i,
   input wire logic [WIDTH-1:0] new_i,
   input wire logic [WIDTH/8-1:0] byte_en_i,
   input wire logic [WIDTH-1:0] mask_i,
   // Merged value.
   output logic [WIDTH-1:0] merged_o
);
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_bit
         assign merged_o[g] = (byte_en_i[g/8] && mask_i[g]) ? new_i[g] : old_i[g];
      end
   endgenerate
endmodule : cfg_byte_merge

// ### rtl/latency_limiter.sv
// Master tenure counter that ends a burst once the latency limit expires without grant.
`timescale 1ns/1ps
module latency_limiter
   import cfg_hdr_pkg::*;
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic reset_i,
   // Limit field and transaction state.
   input wire logic [4:0] lat_field_i,
   input wire logic start_i,
   input wire logic active_i,
   input wire logic gnt_i,
   // Expiry and forced end.
   output logic expired_o,
   output logic stop_o
);
   logic [7:0] count;

   // The counter loads the limit at the start of a transaction and runs down.
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         count <= 8'h00;
      else if (start_i)
         count <= {lat_field_i, 3'b000};
      else if (active_i && count != 8'h00)
         count <= count - 8'h01;
   end

   assign expired_o = active_i && !start_i && (count == 8'h00);
   assign stop_o = expired_o && !gnt_i;

   chk_expiry_stop: assert property (@(posedge clk_i) disable iff (reset_i)
      stop_o |-> (active_i && !gnt_i && count == 8'h00))
      else $error("burst stopped before limit expired");
   chk_count_load: assert property (@(posedge clk_i) disable iff (reset_i)
      start_i |=> count == {$past(lat_field_i), 3'b000})
      else $error("tenure count not loaded from latency field");
   chk_count_step: assert property (@(posedge clk_i) disable iff (reset_i)
      (active_i && !start_i && count != 8'h00) |=> count == $past(count) - 8'h01)
      else $error("tenure count did not step down");
endmodule : latency_limiter

// ### sim/cfg_host_model.sv
// Configuration host model that issues single configuration reads and writes.
`timescale 1ns/1ps
module cfg_host_model
   import cfg_hdr_pkg::*;
(
   // Clock and read data.
   input wire logic clk_i,
   input wire logic [31:0] rdata_i,
   // Access strobe and request.
   output logic sel_o,
   output logic write_o,
   output cfg_write_t req_o
);
   initial
   begin
      sel_o = 1'b0;
      write_o = 1'b0;
      req_o = '0;
   end
   task automatic access(input logic w, input logic [7:0] ofs, input logic [3:0] be,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      sel_o <= 1'b1;
      write_o <= w;
      req_o <= '{offset: ofs, byte_en: be, data: d};
      @(posedge clk_i);
      sel_o <= 1'b0;
      // A released data bus no longer shows the last value.
      req_o.data <= ~d;
      #1 q = rdata_i;
   endtask : access
endmodule : cfg_host_model

// ### sim/tb.sv
// Self-checking bench for the configuration header slice.
`timescale 1ns/1ps
module tb;
   import cfg_hdr_pkg::*;
   typedef struct packed {
      logic [7:0] ofs;
      logic [31:0] wd;
      logic [31:0] mask;
      logic [31:0] exp;
   } row_t;
   localparam logic [7:0] REV = 8'h5A; // Arbitrary value.
   logic clk_i, reset_i, sel, wr, mem_hit, rom_hit, rom_en, claim;
   logic m_req, m_start, m_stop, serr_ev, serr_n, serr_oe;
   cfg_write_t req;
   master_ctl_t m;
   logic [3:0] m_cmd;
   logic [15:0] command;
   logic [31:0] rdata, q;
   int n_mismatch = 0;
   int checked = 0;
   int k;
   row_t rows [6] = '{'{8'h04, 32'hFFFFFFFF, 32'h0000FFFF, 32'h000001F7},
      '{8'h08, 32'hFFFFFFFF, 32'hFFFFFFFF, {24'h048000, REV}},
      '{8'h0C, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0080F800},
      '{8'h0C, 32'h00000000, 32'hFFFFFFFF, 32'h00800000},
      '{8'h04, 32'h00000000, 32'h0000FFFF, 32'h00000000},
      '{8'h40, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h00000000}};
   pci_config_header_fn1 #(.SILICON_REVISION(REV)) uut (.clk_i(clk_i), .reset_i(reset_i),
      .cfg_sel_i(sel), .cfg_write_i(wr), .cfg_req_i(req), .cfg_rdata_o(rdata),
      .mem_hit_i(mem_hit), .rom_hit_i(rom_hit), .rom_decode_en_i(rom_en), .mem_claim_o(claim),
      .master_i(m), .master_req_o(m_req), .master_write_cmd_o(m_cmd),
      .master_start_o(m_start), .master_stop_o(m_stop), .serr_event_i(serr_ev),
      .serr_n_o(serr_n), .serr_oe_o(serr_oe), .command_o(command));
   cfg_host_model host (.clk_i(clk_i), .rdata_i(rdata), .sel_o(sel), .write_o(wr), .req_o(req));
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic serr_try(input logic [1:0] e);
      @(posedge clk_i);
      serr_ev <= 1'b1;
      @(posedge clk_i);
      serr_ev <= 1'b0;
      #1 chk("serr pin", {serr_oe, serr_n}, e);
   endtask : serr_try
   task automatic summarize();
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize
   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   initial
   begin
      #125000;
      n_mismatch++;
      summarize();
   end
   initial
   begin
      reset_i = 1'b1;
      {mem_hit, rom_hit, rom_en, serr_ev} = 4'h0;
      m = '0;
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      #1 chk("reset cmd", command, 32'h0);
      chk("reset serr", {serr_oe, serr_n}, 32'h1);
      host.access(1'b0, OFS_HDR_LAT, 4'hF, 32'h0, q);
      chk("reset latency", q, 32'h00800000);
      foreach (rows[i])
      begin
         host.access(1'b1, rows[i].ofs, 4'hF, rows[i].wd, q);
         host.access(1'b0, rows[i].ofs, 4'hF, 32'h0, q);
         chk("row read", q & rows[i].mask, rows[i].exp);
      end
      for (int b = 1; b < 4; b++)
      begin
         host.access(1'b0, 8'h08 + 8'(b), 4'(1 << b), 32'h0, q);
         chk("class byte", q[8*b +: 8], CLASS_CODE[8*(b-1) +: 8]);
      end
      serr_try(2'b01);
      host.access(1'b1, OFS_COMMAND, 4'h2, 32'h0000FF01, q);
      chk("byte write", command, 32'h0100);
      serr_try(2'b10);
      @(posedge clk_i);
      m <= '{req: 1'b1, want_mwi: 1'b1, gnt: 1'b1, burst_done: 1'b0};
      #1 chk("no master", {m_req, m_start}, 32'h0);
      chk("plain write", m_cmd, PCI_CMD_MEM_WRITE);
      for (int n = 0; n < 3; n++)
      begin
         @(posedge clk_i);
         m <= '0;
         host.access(1'b1, OFS_HDR_LAT, 4'hF, n << LAT_LSB, q);
         host.access(1'b1, OFS_COMMAND, 4'hF, 32'h116, q);
         @(posedge clk_i);
         m <= '{req: 1'b1, want_mwi: 1'b1, gnt: 1'b1, burst_done: 1'b0};
         #1 chk("master go", {m_req, m_start, m_cmd}, {2'b11, PCI_CMD_MWI});
         @(posedge clk_i);
         m.gnt <= 1'b0;
         k = 0;
         #1;
         while (m_stop !== 1'b1 && k < 300)
         begin
            @(posedge clk_i);
            #1 k++;
         end
         chk("tenure", k, LAT_UNIT_CLOCKS * n);
      end
      for (int c = 1; c >= 0; c--)
      begin
         // First pass sets memory decode alone, second pass the I/O bit alone.
         host.access(1'b1, OFS_COMMAND, 4'hF, 32'(c + 1), q);
         for (int i = 0; i < 8; i++)
         begin
            @(posedge clk_i);
            {mem_hit, rom_hit, rom_en} <= 3'(i);
            #1 chk("claim", claim, 32'((c == 1) && (i[2] || (i[1] && i[0]))));
         end
      end
      // Grant still held when the limit runs out: the burst goes on until grant drops.
      host.access(1'b1, OFS_HDR_LAT, 4'hF, 32'h00000800, q);
      host.access(1'b1, OFS_COMMAND, 4'hF, 32'h00000004, q);
      @(posedge clk_i);
      m <= '{req: 1'b1, want_mwi: 1'b1, gnt: 1'b1, burst_done: 1'b0};
      repeat (12) @(posedge clk_i);
      #1 chk("held grant", m_stop, 32'h0);
      chk("mwi refused", m_cmd, PCI_CMD_MEM_WRITE);
      @(posedge clk_i);
      m.gnt <= 1'b0;
      #1 chk("late stop", m_stop, 32'h1);
      @(posedge clk_i);
      m <= '0;
      reset_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      #1 chk("mid reset cmd", command, 32'h0);
      chk("mid reset rdata", rdata, 32'h0);
      chk("mid reset stop", m_stop, 32'h0);
      host.access(1'b0, OFS_HDR_LAT, 4'hF, 32'h0, q);
      chk("mid reset latency", q, 32'h00800000);
      summarize();
   end
endmodule : tb
